// [design/afcb_coef_bank.sv]
/*
  Left-channel effects feedback and de-emphasis feed-forward coefficient bank.
  Assumes a control-bus front end that turns serial transfers into one-cycle
  read and write strobes with a register offset, synchronous to CLK_I.
*/
`timescale 1ns/10ps

// Operation
// RULE1 - Each coefficient is high-byte register above its paired low-byte register; the code puts the high byte at the lower offset, low byte next.
// RULE2 - Each assembled coefficient is used as signed two's-complement.
// RULE3 - Every 16-bit code from -32768 to 32767 is accepted, none reserved.
// RULE4 - Reset loads feedback four with high 0x7D, low 0x83.
// RULE5 - Reset loads feedback five with high 0x84, low 0xEE.
// RULE6 - Reset loads feed-forward zero with high 0x39, low 0x55.
// RULE7 - Reset loads feed-forward one with high 0xF3, low 0x2D.
// RULE8 - All eight bits are read and written; reads return the last write.
// RULE9 - Host writes both bytes before relying on a new coefficient.
module afcb_coef_bank (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_B_I,
  // Register access
  input wire logic [afcb_pkg::AFCB_ADDR_W-1:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_WDATA_I,
  output logic [7:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  output logic REG_RHIT_O,
  // Coefficients to the filters
  output afcb_pkg::afcb_coef_t FB4_COEF_O, // RULE2 RULE3
  output afcb_pkg::afcb_coef_t FB5_COEF_O, // RULE2 RULE3
  output afcb_pkg::afcb_coef_t FF0_COEF_O, // RULE2 RULE3
  output afcb_pkg::afcb_coef_t FF1_COEF_O // RULE2 RULE3
);
  import afcb_pkg::*;

  function automatic logic addr_hit(input logic [AFCB_ADDR_W-1:0] a);
    return (a >= AFCB_OFS_FB4_HIGH) && (a <= AFCB_OFS_FF1_LOW);
  endfunction : addr_hit

  function automatic logic [AFCB_IDX_W-1:0] addr_slot(input logic [AFCB_ADDR_W-1:0] a);
    logic [AFCB_ADDR_W-1:0] diff;
    diff = a - AFCB_OFS_FB4_HIGH;
    return diff[AFCB_IDX_W-1:0];
  endfunction : addr_slot

  afcb_mem_if mem ();

  logic hit;
  logic rvalid_q;
  logic rhit_q;
  logic seen_write_q;

  assign hit = addr_hit(REG_ADDR_I);
  assign mem.idx = addr_slot(REG_ADDR_I);
  assign mem.wr_en = REG_WR_I && hit;
  assign mem.rd_en = REG_RD_I;
  assign mem.rd_hit = hit;
  assign mem.wdata = REG_WDATA_I;

  afcb_byte_store u_store (
    .clk_i(CLK_I),
    .rst_b_i(RST_B_I),
    .mem(mem)
  );

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rvalid_q <= 1'b0;
      rhit_q <= 1'b0;
      seen_write_q <= 1'b0;
    end else begin
      rvalid_q <= REG_RD_I;
      rhit_q <= REG_RD_I && hit;
      seen_write_q <= seen_write_q || mem.wr_en;
    end
  end

  assign REG_RDATA_O = mem.rdata;
  assign REG_RVALID_O = rvalid_q;
  assign REG_RHIT_O = rhit_q;

  // Bytes land one at a time, so the filter can briefly see a mixed value.
  assign FB4_COEF_O = {mem.bytes[AFCB_SLOT_FB4_HIGH], mem.bytes[AFCB_SLOT_FB4_LOW]}; // RULE1 RULE9
  assign FB5_COEF_O = {mem.bytes[AFCB_SLOT_FB5_HIGH], mem.bytes[AFCB_SLOT_FB5_LOW]}; // RULE1 RULE9
  assign FF0_COEF_O = {mem.bytes[AFCB_SLOT_FF0_HIGH], mem.bytes[AFCB_SLOT_FF0_LOW]}; // RULE1 RULE9
  assign FF1_COEF_O = {mem.bytes[AFCB_SLOT_FF1_HIGH], mem.bytes[AFCB_SLOT_FF1_LOW]}; // RULE1 RULE9

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_B_I);

  a_fb4_reset_value: // RULE4
    assert property (!seen_write_q |-> FB4_COEF_O == {AFCB_RST_FB4_HIGH, AFCB_RST_FB4_LOW})
    else $error("Feedback four lost its reset value.");

  a_fb5_reset_value: // RULE5
    assert property (!seen_write_q |-> FB5_COEF_O == {AFCB_RST_FB5_HIGH, AFCB_RST_FB5_LOW})
    else $error("Feedback five lost its reset value.");

  a_ff0_reset_value: // RULE6
    assert property (!seen_write_q |-> FF0_COEF_O == {AFCB_RST_FF0_HIGH, AFCB_RST_FF0_LOW})
    else $error("Feed-forward zero lost its reset value.");

  a_ff1_reset_value: // RULE7
    assert property (!seen_write_q |-> FF1_COEF_O == {AFCB_RST_FF1_HIGH, AFCB_RST_FF1_LOW})
    else $error("Feed-forward one lost its reset value.");

  a_high_byte_write: // RULE1
    assert property ((REG_WR_I && REG_ADDR_I == AFCB_OFS_FB4_HIGH) |=>
      (FB4_COEF_O[15:8] == $past(REG_WDATA_I)) && $stable(FB4_COEF_O[7:0]))
    else $error("High-byte write did not land in the upper coefficient byte.");

  a_low_byte_write: // RULE1
    assert property ((REG_WR_I && REG_ADDR_I == AFCB_OFS_FF1_LOW) |=>
      (FF1_COEF_O[7:0] == $past(REG_WDATA_I)) && $stable(FF1_COEF_O[15:8]))
    else $error("Low-byte write did not land in the lower coefficient byte.");

  a_full_range_code: // RULE2 RULE3
    assert property ((REG_WR_I && REG_ADDR_I == AFCB_OFS_FB5_HIGH && REG_WDATA_I == 8'h80)
      ##1 (REG_WR_I && REG_ADDR_I == AFCB_OFS_FB5_LOW && REG_WDATA_I == 8'h00) |=>
      (FB5_COEF_O == -16'sd32768) && (FB5_COEF_O < 0))
    else $error("Most negative code was not kept as a negative coefficient.");

  a_write_read_back: // RULE8
    assert property ((REG_WR_I && hit) ##1 (REG_RD_I && !REG_WR_I &&
      REG_ADDR_I == $past(REG_ADDR_I)) |=> REG_RVALID_O && REG_RHIT_O &&
      (REG_RDATA_O == $past(REG_WDATA_I, 2)))
    else $error("Read-back differs from the last written byte.");

  a_unmapped_read: // RULE8
    assert property ((REG_RD_I && !hit) |=> REG_RVALID_O && !REG_RHIT_O &&
      (REG_RDATA_O == AFCB_UNMAPPED_DATA))
    else $error("Unmapped read did not return zero.");

  a_unmapped_write: // RULE8
    assert property ((REG_WR_I && !hit) |=> $stable(FB4_COEF_O) && $stable(FB5_COEF_O) &&
      $stable(FF0_COEF_O) && $stable(FF1_COEF_O))
    else $error("Unmapped write changed a coefficient.");

  // Bytes are checked through the outputs the filters see, so a slip in slot decoding shows up.
  a_fb4_low_write: // RULE1
    assert property ((REG_WR_I && REG_ADDR_I == AFCB_OFS_FB4_LOW) |=>
      (FB4_COEF_O[7:0] == $past(REG_WDATA_I)) && $stable(FB4_COEF_O[15:8]))
    else $error("Low-byte write to feedback four did not land.");

  a_fb5_high_write: // RULE1
    assert property ((REG_WR_I && REG_ADDR_I == AFCB_OFS_FB5_HIGH) |=>
      (FB5_COEF_O[15:8] == $past(REG_WDATA_I)) && $stable(FB5_COEF_O[7:0]))
    else $error("High-byte write to feedback five did not land.");

  a_fb5_low_write: // RULE1
    assert property ((REG_WR_I && REG_ADDR_I == AFCB_OFS_FB5_LOW) |=>
      (FB5_COEF_O[7:0] == $past(REG_WDATA_I)) && $stable(FB5_COEF_O[15:8]))
    else $error("Low-byte write to feedback five did not land.");

  a_ff0_high_write: // RULE1
    assert property ((REG_WR_I && REG_ADDR_I == AFCB_OFS_FF0_HIGH) |=>
      (FF0_COEF_O[15:8] == $past(REG_WDATA_I)) && $stable(FF0_COEF_O[7:0]))
    else $error("High-byte write to feed-forward zero did not land.");

  a_ff0_low_write: // RULE1
    assert property ((REG_WR_I && REG_ADDR_I == AFCB_OFS_FF0_LOW) |=>
      (FF0_COEF_O[7:0] == $past(REG_WDATA_I)) && $stable(FF0_COEF_O[15:8]))
    else $error("Low-byte write to feed-forward zero did not land.");

  a_ff1_high_write: // RULE1
    assert property ((REG_WR_I && REG_ADDR_I == AFCB_OFS_FF1_HIGH) |=>
      (FF1_COEF_O[15:8] == $past(REG_WDATA_I)) && $stable(FF1_COEF_O[7:0]))
    else $error("High-byte write to feed-forward one did not land.");

  a_fb4_high_read: // RULE8
    assert property ((REG_RD_I && REG_ADDR_I == AFCB_OFS_FB4_HIGH) |=>
      REG_RDATA_O == $past(FB4_COEF_O[15:8]))
    else $error("Read of feedback four high byte differs from the coefficient.");

  a_fb4_low_read: // RULE8
    assert property ((REG_RD_I && REG_ADDR_I == AFCB_OFS_FB4_LOW) |=>
      REG_RDATA_O == $past(FB4_COEF_O[7:0]))
    else $error("Read of feedback four low byte differs from the coefficient.");

  a_fb5_high_read: // RULE8
    assert property ((REG_RD_I && REG_ADDR_I == AFCB_OFS_FB5_HIGH) |=>
      REG_RDATA_O == $past(FB5_COEF_O[15:8]))
    else $error("Read of feedback five high byte differs from the coefficient.");

  a_fb5_low_read: // RULE8
    assert property ((REG_RD_I && REG_ADDR_I == AFCB_OFS_FB5_LOW) |=>
      REG_RDATA_O == $past(FB5_COEF_O[7:0]))
    else $error("Read of feedback five low byte differs from the coefficient.");

  a_ff0_high_read: // RULE8
    assert property ((REG_RD_I && REG_ADDR_I == AFCB_OFS_FF0_HIGH) |=>
      REG_RDATA_O == $past(FF0_COEF_O[15:8]))
    else $error("Read of feed-forward zero high byte differs from the coefficient.");

  a_ff0_low_read: // RULE8
    assert property ((REG_RD_I && REG_ADDR_I == AFCB_OFS_FF0_LOW) |=>
      REG_RDATA_O == $past(FF0_COEF_O[7:0]))
    else $error("Read of feed-forward zero low byte differs from the coefficient.");

  a_ff1_high_read: // RULE8
    assert property ((REG_RD_I && REG_ADDR_I == AFCB_OFS_FF1_HIGH) |=>
      REG_RDATA_O == $past(FF1_COEF_O[15:8]))
    else $error("Read of feed-forward one high byte differs from the coefficient.");

  a_ff1_low_read: // RULE8
    assert property ((REG_RD_I && REG_ADDR_I == AFCB_OFS_FF1_LOW) |=>
      REG_RDATA_O == $past(FF1_COEF_O[7:0]))
    else $error("Read of feed-forward one low byte differs from the coefficient.");

  a_read_valid_pulse: // RULE8
    assert property (REG_RD_I |=> REG_RVALID_O)
    else $error("Read strobe was not answered one cycle later.");

  a_idle_no_valid: // RULE8
    assert property (!REG_RD_I |=> !REG_RVALID_O)
    else $error("Read valid rose without a read strobe.");

  a_rhit_with_valid: // RULE8
    assert property (REG_RHIT_O |-> REG_RVALID_O)
    else $error("Read hit flag stood without read valid.");

  a_mapped_read_hit: // RULE8
    assert property ((REG_RD_I && hit) |=> REG_RHIT_O)
    else $error("Mapped read did not raise the hit flag.");

  a_rdata_hold: // RULE8
    assert property (!REG_RD_I |=> $stable(REG_RDATA_O))
    else $error("Read data changed without a read.");

  a_coef_hold: // RULE8
    assert property (!REG_WR_I |=> $stable(FB4_COEF_O) && $stable(FB5_COEF_O) &&
      $stable(FF0_COEF_O) && $stable(FF1_COEF_O))
    else $error("A coefficient changed without a write.");

endmodule : afcb_coef_bank

// [include/afcb_pkg.sv]
/*
  Constants for the left-channel filter coefficient bank: register offsets,
  byte slots, reset values and the coefficient type.
  Assumes page selection happens outside this bank.
*/
package afcb_pkg;

  localparam int AFCB_NUM_BYTES = 8;
  localparam int AFCB_ADDR_W = 7;
  localparam int AFCB_IDX_W = 3;

  // Register offsets on the control page.
  localparam logic [6:0] AFCB_OFS_FB4_HIGH = 7'h11;
  localparam logic [6:0] AFCB_OFS_FB4_LOW = 7'h12;
  localparam logic [6:0] AFCB_OFS_FB5_HIGH = 7'h13;
  localparam logic [6:0] AFCB_OFS_FB5_LOW = 7'h14;
  localparam logic [6:0] AFCB_OFS_FF0_HIGH = 7'h15;
  localparam logic [6:0] AFCB_OFS_FF0_LOW = 7'h16;
  localparam logic [6:0] AFCB_OFS_FF1_HIGH = 7'h17;
  localparam logic [6:0] AFCB_OFS_FF1_LOW = 7'h18;

  // Byte slots inside the store; slot equals offset minus the first offset.
  localparam logic [2:0] AFCB_SLOT_FB4_HIGH = 3'h0;
  localparam logic [2:0] AFCB_SLOT_FB4_LOW = 3'h1;
  localparam logic [2:0] AFCB_SLOT_FB5_HIGH = 3'h2;
  localparam logic [2:0] AFCB_SLOT_FB5_LOW = 3'h3;
  localparam logic [2:0] AFCB_SLOT_FF0_HIGH = 3'h4;
  localparam logic [2:0] AFCB_SLOT_FF0_LOW = 3'h5;
  localparam logic [2:0] AFCB_SLOT_FF1_HIGH = 3'h6;
  localparam logic [2:0] AFCB_SLOT_FF1_LOW = 3'h7;

  // Reset values.
  localparam logic [7:0] AFCB_RST_FB4_HIGH = 8'h7D;
  localparam logic [7:0] AFCB_RST_FB4_LOW = 8'h83;
  localparam logic [7:0] AFCB_RST_FB5_HIGH = 8'h84;
  localparam logic [7:0] AFCB_RST_FB5_LOW = 8'hEE;
  localparam logic [7:0] AFCB_RST_FF0_HIGH = 8'h39;
  localparam logic [7:0] AFCB_RST_FF0_LOW = 8'h55;
  localparam logic [7:0] AFCB_RST_FF1_HIGH = 8'hF3;
  localparam logic [7:0] AFCB_RST_FF1_LOW = 8'h2D;

  localparam logic [7:0] AFCB_RST_BYTES [AFCB_NUM_BYTES] = '{
    AFCB_RST_FB4_HIGH, AFCB_RST_FB4_LOW, AFCB_RST_FB5_HIGH, AFCB_RST_FB5_LOW,
    AFCB_RST_FF0_HIGH, AFCB_RST_FF0_LOW, AFCB_RST_FF1_HIGH, AFCB_RST_FF1_LOW
  };

  localparam logic [7:0] AFCB_UNMAPPED_DATA = 8'h00;

  typedef logic signed [15:0] afcb_coef_t;
  typedef logic [7:0] afcb_byte_t;

endpackage : afcb_pkg

// [include/afcb_mem_if.sv]
/*
  Carrier between the bank's decoder and its byte store.
  Assumes both ends share one clock.
*/
`timescale 1ns/10ps
interface afcb_mem_if;
  import afcb_pkg::*;

  logic wr_en;
  logic rd_en;
  logic rd_hit;
  logic [2:0] idx;
  afcb_byte_t wdata;
  afcb_byte_t rdata;
  afcb_byte_t bytes [AFCB_NUM_BYTES];

  modport ctrl (output wr_en, rd_en, rd_hit, idx, wdata, input rdata, bytes);
  modport store (input wr_en, rd_en, rd_hit, idx, wdata, output rdata, bytes);
endinterface : afcb_mem_if

// [design/afcb_byte_store.sv]
/*
  Eight byte-wide coefficient registers with their reset values and a
  registered read port.
  Assumes the decoder delivers a valid slot whenever a write is enabled.
*/
`timescale 1ns/10ps
module afcb_byte_store (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Store side of the carrier
  afcb_mem_if.store mem
);
  import afcb_pkg::*;

  afcb_byte_t rdata_q;

  genvar g;
  generate
    for (g = 0; g < AFCB_NUM_BYTES; g++) begin : g_byte
      afcb_byte_t byte_q;
      always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          byte_q <= AFCB_RST_BYTES[g]; // RULE4 RULE5 RULE6 RULE7
        end else if (mem.wr_en && (mem.idx == 3'(g))) begin
          byte_q <= mem.wdata; // RULE8
        end
      end
      assign mem.bytes[g] = byte_q;
    end
  endgenerate

  // A read in the same cycle as a write to that byte returns the old value.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_q <= AFCB_UNMAPPED_DATA;
    end else if (mem.rd_en) begin
      rdata_q <= mem.rd_hit ? mem.bytes[mem.idx] : AFCB_UNMAPPED_DATA; // RULE8
    end
  end

  assign mem.rdata = rdata_q;

endmodule : afcb_byte_store

// [verif/afcb_host_model.sv]
/*
  Host controller model that issues one-cycle read and write strobes.
  Assumes the bank takes a strobe at a rising clock edge.
*/
`timescale 1ns/10ps
module afcb_host_model (
  // Clock
  input wire logic clk_i,
  // Strobes to the bank
  output logic [6:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] wdata_o
);
  initial begin
    addr_o = 7'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
  end
  task automatic put(input logic [6:0] a, input logic [7:0] d, input logic w);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= w;
    rd_o <= !w;
    @(posedge clk_i);
  endtask : put
  // Released address and data lines show the inverse so a stale value is never mistaken for a live one.
  task automatic idle();
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    addr_o <= ~addr_o;
    wdata_o <= ~wdata_o;
  endtask : idle
  task automatic wcoef(input logic [6:0] a, input logic [15:0] v);
    put(a, v[15:8], 1'b1);
    put(a + 7'h01, v[7:0], 1'b1);
    idle();
  endtask : wcoef
endmodule : afcb_host_model

// [verif/audio_filter_coefficient_bank_bench.sv]
/*
  Self-checking bench for the coefficient bank.
  Assumes the bank answers reads one cycle after the strobe.
*/
`timescale 1ns/10ps
module audio_filter_coefficient_bank_bench;
  import afcb_pkg::*;
  logic clk, rst_b, wr, rd, rvalid, rhit;
  logic [6:0] addr;
  logic [7:0] wdata, rdata;
  afcb_coef_t coef [4];
  logic [15:0] model [4];
  logic [15:0] v;
  int n_errors, compares, seed;
  afcb_coef_bank u_afcb_coef_bank (.CLK_I(clk), .RST_B_I(rst_b), .REG_ADDR_I(addr),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
    .REG_RVALID_O(rvalid), .REG_RHIT_O(rhit), .FB4_COEF_O(coef[0]),
    .FB5_COEF_O(coef[1]), .FF0_COEF_O(coef[2]), .FF1_COEF_O(coef[3]));
  afcb_host_model u_afcb_host_model (.clk_i(clk), .addr_o(addr), .wr_o(wr), .rd_o(rd),
    .wdata_o(wdata));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [15:0] pack(input logic [7:0] hi, input logic [7:0] lo);
    return {hi, lo};
  endfunction : pack
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp, input logic hit);
    u_afcb_host_model.put(a, 8'h00, 1'b0);
    u_afcb_host_model.idle();
    #1;
    check("rvalid", 16'h0001, {15'h0000, rvalid});
    check("rdata", {8'h00, exp}, {8'h00, rdata});
    check("rhit", {15'h0000, hit}, {15'h0000, rhit});
    @(posedge clk);
  endtask : rd_chk
  task automatic print_verdict();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict
  initial begin
    n_errors = 0;
    compares = 0;
    seed = 28192;
    rst_b = 1'b0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      model[i] = pack(AFCB_RST_BYTES[2*i], AFCB_RST_BYTES[2*i+1]);
      check("reset coef", model[i], coef[i]);
    end
    for (int j = 0; j < 8; j++) rd_chk(7'h11 + 7'(j), AFCB_RST_BYTES[j], 1'b1);
    for (int k = 0; k < 12; k++) begin
      v = (k == 0) ? 16'h7FFF : (k == 1) ? 16'h8000 : (k == 2) ? 16'hFFFF : 16'($random(seed));
      u_afcb_host_model.wcoef(7'h11 + 7'(2*(k%4)), v);
      model[k%4] = v;
      #1;
      check("coef", model[k%4], coef[k%4]);
      check("sign", {15'h0000, v[15]}, {15'h0000, coef[k%4] < 16'sh0000});
      @(posedge clk);
    end
    u_afcb_host_model.wcoef(7'h18, 16'hA55A);
    @(posedge clk);
    u_afcb_host_model.wcoef(7'h0F, 16'h5AA5);
    model[3][7:0] = 8'hA5;
    #1;
    @(posedge clk);
    model[2][15:8] = 8'hC3;
    u_afcb_host_model.put(7'h15, 8'hC3, 1'b1);
    rd_chk(7'h15, 8'hC3, 1'b1);
    for (int j = 0; j < 8; j++)
      rd_chk(7'h11 + 7'(j), j[0] ? model[j/2][7:0] : model[j/2][15:8], 1'b1);
    rd_chk(7'h19, 8'h00, 1'b0);
    rd_chk(7'h10, 8'h00, 1'b0);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      model[i] = pack(AFCB_RST_BYTES[2*i], AFCB_RST_BYTES[2*i+1]);
      check("coef after reset", model[i], coef[i]);
    end
    rd_chk(7'h17, AFCB_RST_FF1_HIGH, 1'b1);
    print_verdict();
  end
endmodule : audio_filter_coefficient_bank_bench
